// ---- core/tmor_pkg.sv ----
// tmor_pkg: register map, field positions and reset values of the thermal monitor register bank
// assumes a byte-wide register port driven by the management bus front end
package tmor_pkg;
    // ----------------------------------------
    // read and write addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_LOCAL_TEMP = 8'h00;
    localparam logic [7:0] ADDR_REMOTE_HI = 8'h01;
    localparam logic [7:0] ADDR_STATUS1 = 8'h02;
    localparam logic [7:0] RD_CONFIG = 8'h03;
    localparam logic [7:0] RD_CONV_RATE = 8'h04;
    localparam logic [7:0] RD_LOCAL_HIGH = 8'h05;
    localparam logic [7:0] RD_LOCAL_LOW = 8'h06;
    localparam logic [7:0] RD_REMOTE_HIGH = 8'h07;
    localparam logic [7:0] RD_REMOTE_LOW = 8'h08;
    localparam logic [7:0] WR_CONFIG = 8'h09;
    localparam logic [7:0] WR_CONV_RATE = 8'h0A;
    localparam logic [7:0] WR_LOCAL_HIGH = 8'h0B;
    localparam logic [7:0] WR_LOCAL_LOW = 8'h0C;
    localparam logic [7:0] WR_REMOTE_HIGH = 8'h0D;
    localparam logic [7:0] WR_REMOTE_LOW = 8'h0E;
    localparam logic [7:0] ADDR_ONE_SHOT = 8'h0F;
    localparam logic [7:0] ADDR_REMOTE_LO = 8'h10;
    localparam logic [7:0] ADDR_OFS1_HI = 8'h11;
    localparam logic [7:0] ADDR_OFS1_LO = 8'h12;
    localparam logic [7:0] ADDR_FAULT_Q = 8'h22;
    localparam logic [7:0] ADDR_OFS2_HI = 8'h34;
    localparam logic [7:0] ADDR_OFS2_LO = 8'h35;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CFG_BANK_BIT = 3;
    localparam int CFG_STANDBY_BIT = 6;
    localparam int FQ_SCL_TMO_BIT = 7;
    localparam int FQ_SDA_TMO_BIT = 6;
    localparam int FQ_MASK_LOCAL_BIT = 5;
    localparam logic [7:0] OFS_LO_MASK = 8'hC0;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_CONV_RATE = 8'h07;
    localparam logic [7:0] RST_HIGH_LIMIT = 8'h55;
    localparam logic [7:0] RST_FAULT_Q = 8'h01;
    localparam logic [3:0] RST_FAULT_CNT = 4'h0;
    // ----------------------------------------
    // single-conversion states
    // ----------------------------------------
    typedef enum logic [1:0] {
        TMOR_IDLE = 2'b00,
        TMOR_LOCAL = 2'b01,
        TMOR_REMOTE1 = 2'b10,
        TMOR_REMOTE2 = 2'b11
    } tmor_conv_t;
endpackage

// ---- core/tmor_fault_queue.sv ----
// tmor_fault_queue: consecutive out-of-limit counter for one alert source
// assumes one i_meas pulse per finished measurement with its out-of-limit level
module tmor_fault_queue (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // queue setting
    input wire logic [3:0] i_queue_code,
    // measurement result
    input wire logic i_meas,
    input wire logic i_out_of_limit,
    // result
    output logic o_alert
);
    typedef struct packed {
        logic [3:0] cnt;
        logic alert;
    } tmor_fq_state_t;

    tmor_fq_state_t st_reg;
    tmor_fq_state_t st_next;
    logic [3:0] need;

    // decode of required run length, bit 0 ignored
    always_comb begin
        case (i_queue_code[3:1])
            3'b001: need = 4'h2;
            3'b011: need = 4'h3;
            3'b111: need = 4'h4;
            default: need = 4'h1;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        if (i_meas) begin
            if (i_out_of_limit) begin
                if (st_reg.cnt < need) begin
                    st_next.cnt = st_reg.cnt + 4'h1;
                end
                st_next.alert = ((st_reg.cnt + 4'h1) >= need);
            end else begin
                st_next.cnt = tmor_pkg::RST_FAULT_CNT;
                st_next.alert = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_alert = st_reg.alert;
endmodule

// ---- core/tmor_regs.sv ----
// tmor_regs: register bank with offsets, bank aliasing, single conversion and fault queue
// assumes a bus front end presenting byte reads and writes with a one-cycle strobe,
// and a converter that returns one raw reading per request
module tmor_regs (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    // converter
    input wire logic i_meas_done,
    input wire logic [1:0] i_meas_chan,
    input wire logic [9:0] i_meas_raw,
    input wire logic i_local_out_of_limit,
    input wire logic i_remote_out_of_limit,
    input wire logic [7:0] i_status1,
    // register read data
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    // conversion control
    output logic o_conv_req,
    output logic [1:0] o_conv_chan,
    output logic o_busy,
    // configuration and alert request seen by the rest of the device
    output logic [7:0] o_config,
    output logic [7:0] o_conv_rate,
    output logic o_scl_timeout_en,
    output logic o_sda_timeout_en,
    output logic o_alert_req
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] rate;
        logic [7:0] lhigh;
        logic [7:0] llow;
        logic [7:0] r1high;
        logic [7:0] r1low;
        logic [7:0] r2high;
        logic [7:0] r2low;
        logic [7:0] fq;
        logic [7:0] local_t;
        logic [9:0] r1_t;
        logic [9:0] r2_t;
        logic [9:0] ofs1;
        logic [9:0] ofs2;
        tmor_pkg::tmor_conv_t conv;
        logic req;
        logic [7:0] rdata;
        logic rvalid;
        logic busy;
        logic alert;
    } tmor_state_t;

    tmor_state_t st_reg;
    tmor_state_t st_next;
    logic bank2;
    logic meas_local;
    logic meas_remote;
    logic local_alert;
    logic remote_alert;

    // one offset register read at byte granularity
    function automatic logic [7:0] ofs_byte(input logic [9:0] ofs, input logic lo);
        if (lo) begin
            ofs_byte = {ofs[1:0], 6'h00};
        end else begin
            ofs_byte = ofs[9:2];
        end
    endfunction

    // sign-extended sum in quarter degrees, saturated to ten bits
    function automatic logic [9:0] add_ofs(input logic [9:0] raw, input logic [9:0] ofs);
        logic signed [10:0] sum;
        sum = 11'(signed'(raw)) + 11'(signed'(ofs));
        if (sum > 11'sd511) begin
            add_ofs = 10'h1FF;
        end else if (sum < -11'sd512) begin
            add_ofs = 10'h200;
        end else begin
            add_ofs = sum[9:0];
        end
    endfunction

    assign bank2 = st_reg.cfg[tmor_pkg::CFG_BANK_BIT];
    assign meas_local = i_meas_done && (i_meas_chan == 2'b01);
    assign meas_remote = i_meas_done && (i_meas_chan != 2'b01);

    tmor_fault_queue u_fq_local (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_queue_code(st_reg.fq[3:0]),
        .i_meas(meas_local),
        .i_out_of_limit(i_local_out_of_limit),
        .o_alert(local_alert)
    );

    tmor_fault_queue u_fq_remote (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_queue_code(st_reg.fq[3:0]),
        .i_meas(meas_remote),
        .i_out_of_limit(i_remote_out_of_limit),
        .o_alert(remote_alert)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.rvalid = i_rd;
        st_next.req = 1'b0;

        // register writes; read-only and unmapped addresses fall to default
        if (i_wr) begin
            case (i_addr)
                tmor_pkg::WR_CONFIG: st_next.cfg = i_wdata;
                tmor_pkg::WR_CONV_RATE: st_next.rate = i_wdata;
                tmor_pkg::WR_LOCAL_HIGH: st_next.lhigh = i_wdata;
                tmor_pkg::WR_LOCAL_LOW: st_next.llow = i_wdata;
                tmor_pkg::WR_REMOTE_HIGH: begin
                    if (bank2) begin
                        st_next.r2high = i_wdata;
                    end else begin
                        st_next.r1high = i_wdata;
                    end
                end
                tmor_pkg::WR_REMOTE_LOW: begin
                    if (bank2) begin
                        st_next.r2low = i_wdata;
                    end else begin
                        st_next.r1low = i_wdata;
                    end
                end
                tmor_pkg::ADDR_OFS1_HI: begin
                    if (bank2) begin
                        st_next.ofs2[9:2] = i_wdata;
                    end else begin
                        st_next.ofs1[9:2] = i_wdata;
                    end
                end
                tmor_pkg::ADDR_OFS1_LO: begin
                    if (bank2) begin
                        st_next.ofs2[1:0] = i_wdata[7:6];
                    end else begin
                        st_next.ofs1[1:0] = i_wdata[7:6];
                    end
                end
                tmor_pkg::ADDR_OFS2_HI: st_next.ofs2[9:2] = i_wdata;
                tmor_pkg::ADDR_OFS2_LO: st_next.ofs2[1:0] = i_wdata[7:6];
                tmor_pkg::ADDR_FAULT_Q: st_next.fq = i_wdata;
                tmor_pkg::ADDR_ONE_SHOT: begin
                    // data discarded, the write starts a pass only in standby with no pass running
                    if (st_reg.cfg[tmor_pkg::CFG_STANDBY_BIT] &&
                        st_reg.conv == tmor_pkg::TMOR_IDLE) begin
                        st_next.conv = tmor_pkg::TMOR_LOCAL;
                        st_next.req = 1'b1;
                    end
                end
                default: begin
                    st_next.cfg = st_reg.cfg;
                end
            endcase
        end

        // remote results with offset applied before they are stored; local result stored as raw[9:2] without offset
        if (meas_local) begin
            st_next.local_t = i_meas_raw[9:2];
        end
        if (meas_remote) begin
            if (i_meas_chan == 2'b11) begin
                st_next.r2_t = add_ofs(i_meas_raw, st_reg.ofs2);
            end else begin
                st_next.r1_t = add_ofs(i_meas_raw, st_reg.ofs1);
            end
        end

        // single pass: local, remote 1, remote 2, then back to standby
        if (i_meas_done) begin
            case (st_reg.conv)
                tmor_pkg::TMOR_LOCAL: begin
                    st_next.conv = tmor_pkg::TMOR_REMOTE1;
                    st_next.req = 1'b1;
                end
                tmor_pkg::TMOR_REMOTE1: begin
                    st_next.conv = tmor_pkg::TMOR_REMOTE2;
                    st_next.req = 1'b1;
                end
                tmor_pkg::TMOR_REMOTE2: st_next.conv = tmor_pkg::TMOR_IDLE;
                default: st_next.conv = st_reg.conv;
            endcase
        end

        // read mux
        case (i_addr)
            tmor_pkg::ADDR_LOCAL_TEMP: st_next.rdata = st_reg.local_t;
            tmor_pkg::ADDR_REMOTE_HI: st_next.rdata = bank2 ? st_reg.r2_t[9:2]
                                                            : st_reg.r1_t[9:2];
            tmor_pkg::ADDR_REMOTE_LO: st_next.rdata = bank2 ? {st_reg.r2_t[1:0], 6'h00}
                                                            : {st_reg.r1_t[1:0], 6'h00};
            tmor_pkg::ADDR_STATUS1: st_next.rdata = i_status1;
            tmor_pkg::RD_CONFIG: st_next.rdata = st_reg.cfg;
            tmor_pkg::RD_CONV_RATE: st_next.rdata = st_reg.rate;
            tmor_pkg::RD_LOCAL_HIGH: st_next.rdata = st_reg.lhigh;
            tmor_pkg::RD_LOCAL_LOW: st_next.rdata = st_reg.llow;
            tmor_pkg::RD_REMOTE_HIGH: st_next.rdata = bank2 ? st_reg.r2high : st_reg.r1high;
            tmor_pkg::RD_REMOTE_LOW: st_next.rdata = bank2 ? st_reg.r2low : st_reg.r1low;
            tmor_pkg::ADDR_OFS1_HI: st_next.rdata = ofs_byte(bank2 ? st_reg.ofs2
                                                                   : st_reg.ofs1, 1'b0);
            tmor_pkg::ADDR_OFS1_LO: st_next.rdata = ofs_byte(bank2 ? st_reg.ofs2
                                                                   : st_reg.ofs1, 1'b1);
            tmor_pkg::ADDR_OFS2_HI: st_next.rdata = ofs_byte(st_reg.ofs2, 1'b0);
            tmor_pkg::ADDR_OFS2_LO: st_next.rdata = ofs_byte(st_reg.ofs2, 1'b1);
            tmor_pkg::ADDR_FAULT_Q: st_next.rdata = st_reg.fq;
            default: st_next.rdata = tmor_pkg::RST_ZERO;
        endcase

        // pass flag and masked alert kept in flops so the outputs have no logic after them
        st_next.busy = (st_next.conv != tmor_pkg::TMOR_IDLE);
        st_next.alert = (local_alert && !st_reg.fq[tmor_pkg::FQ_MASK_LOCAL_BIT]) ||
                        remote_alert;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_reg.cfg <= tmor_pkg::RST_ZERO;
            st_reg.rate <= tmor_pkg::RST_CONV_RATE;
            st_reg.lhigh <= tmor_pkg::RST_HIGH_LIMIT;
            st_reg.llow <= tmor_pkg::RST_ZERO;
            st_reg.r1high <= tmor_pkg::RST_HIGH_LIMIT;
            st_reg.r1low <= tmor_pkg::RST_ZERO;
            st_reg.r2high <= tmor_pkg::RST_HIGH_LIMIT;
            st_reg.r2low <= tmor_pkg::RST_ZERO;
            st_reg.fq <= tmor_pkg::RST_FAULT_Q;
            st_reg.local_t <= tmor_pkg::RST_ZERO;
            st_reg.r1_t <= '0;
            st_reg.r2_t <= '0;
            st_reg.ofs1 <= '0;
            st_reg.ofs2 <= '0;
            st_reg.conv <= tmor_pkg::TMOR_IDLE;
            st_reg.req <= 1'b0;
            st_reg.rdata <= tmor_pkg::RST_ZERO;
            st_reg.rvalid <= 1'b0;
            st_reg.busy <= 1'b0;
            st_reg.alert <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_rdata = st_reg.rdata;
    assign o_rvalid = st_reg.rvalid;
    assign o_conv_req = st_reg.req;
    assign o_conv_chan = st_reg.conv;
    assign o_busy = st_reg.busy;
    assign o_config = st_reg.cfg;
    assign o_conv_rate = st_reg.rate;
    assign o_scl_timeout_en = st_reg.fq[tmor_pkg::FQ_SCL_TMO_BIT];
    assign o_sda_timeout_en = st_reg.fq[tmor_pkg::FQ_SDA_TMO_BIT];
    assign o_alert_req = st_reg.alert;
endmodule

// ---- verif/tmor_conv_model.sv ----
// tmor_conv_model: converter stand-in answering each conversion request of a pass
// assumes single-cycle requests with the pass channel held alongside
module tmor_conv_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // request side
    input wire logic i_req,
    input wire logic [1:0] i_chan,
    input wire logic i_slow,
    input wire logic [29:0] i_raw,
    // result side
    output logic o_done,
    output logic [1:0] o_chan,
    output logic [9:0] o_raw
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt;
    logic [9:0] val;
    // result line toggles outside the done cycle so a stale value is never read
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt <= 5'h00;
            val <= 10'h000;
            o_done <= 1'b0;
            o_chan <= 2'b00;
            o_raw <= 10'h000;
        end else begin
            o_done <= cnt == 5'h01;
            o_raw <= (cnt == 5'h01) ? val : ~o_raw;
            if (i_req) begin
                cnt <= i_slow ? 5'h14 : 5'h01;
                o_chan <= i_chan;
                val <= i_raw[10 * (i_chan - 2'b01) +: 10];
            end else if (cnt != 5'h00) begin
                cnt <= cnt - 5'h01;
            end
        end
    end
endmodule

// ---- verif/tmor_regs_sva.sv ----
// tmor_regs_sva: port-level checks of the register bank
// assumes one clock domain with the asynchronous high reset
module tmor_regs_sva (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // inputs
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_meas_done,
    // outputs
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic o_conv_req,
    input wire logic [1:0] o_conv_chan,
    input wire logic o_busy,
    input wire logic [7:0] o_config,
    input wire logic [7:0] o_conv_rate,
    input wire logic o_scl_timeout_en,
    input wire logic o_sda_timeout_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // ----
    // pass steps
    // ----
    sequence shot_taken;
        i_wr && i_addr == 8'h0F && o_config[6] && !o_busy;
    endsequence
    sequence pass_step;
        i_meas_done && o_busy && o_conv_chan != 2'b11;
    endsequence
    a_rd_answer: assert property (i_rd |=> o_rvalid)
        else $error("read got no answer");
    a_rvalid_cause: assert property (o_rvalid |-> $past(i_rd))
        else $error("answer without read");
    a_trigger_nodata: assert property (i_rd && i_addr == 8'h0F |=> o_rdata == 8'h00)
        else $error("trigger address returned data");
    a_shot_start: assert property (shot_taken |=> o_conv_req && o_busy && o_conv_chan == 2'b01)
        else $error("single pass did not start");
    a_shot_refused: assert property (i_wr && i_addr == 8'h0F && !o_config[6] && !o_busy
        |=> !o_conv_req && !o_busy)
        else $error("pass started outside standby");
    a_pass_order: assert property (pass_step |=> o_conv_req
        && o_conv_chan == $past(o_conv_chan) + 2'b01)
        else $error("pass channel order wrong");
    a_busy_hold: assert property (o_busy && !i_meas_done |=> o_busy)
        else $error("busy dropped mid pass");
    a_pass_end: assert property (i_meas_done && o_conv_chan == 2'b11 |=> !o_busy ##1 !o_conv_req)
        else $error("pass did not return to standby");
    a_cfg_split: assert property (i_wr && i_addr == 8'h09 |=> o_config == $past(i_wdata))
        else $error("config write address failed");
    a_cfg_ro: assert property (i_wr && i_addr == 8'h03 |=> $stable(o_config))
        else $error("config changed by read address");
    a_rate_split: assert property (i_wr && i_addr == 8'h0A |=> o_conv_rate == $past(i_wdata))
        else $error("rate write address failed");
    a_timeout_bits: assert property (i_wr && i_addr == 8'h22
        |=> ($past(i_wdata) & 8'hC0) == {o_scl_timeout_en, o_sda_timeout_en, 6'h00})
        else $error("timeout enables wrong");
endmodule
bind tmor_regs tmor_regs_sva chk_u (.*);

// ---- verif/tb_top.sv ----
// tb_top: register-level tests of the thermal monitor register bank
// assumes the converter stand-in answers every conversion request
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_meas_done;
    logic [1:0] i_meas_chan;
    logic [9:0] i_meas_raw;
    logic i_local_out_of_limit = 1'b0;
    logic i_remote_out_of_limit = 1'b0;
    logic [7:0] i_status1 = 8'hA5;
    logic [7:0] o_rdata;
    logic o_rvalid;
    logic o_conv_req;
    logic [1:0] o_conv_chan;
    logic o_busy;
    logic [7:0] o_config;
    logic [7:0] o_conv_rate;
    logic o_scl_timeout_en;
    logic o_sda_timeout_en;
    logic o_alert_req;
    logic slow = 1'b0;
    int errors = 0;
    int total_checks = 0;
    int i;
    int n;
    int k;
    logic [15:0] rst_tab [15] = '{16'h0000, 16'h0100, 16'h0300, 16'h0407, 16'h0555,
        16'h0600, 16'h0755, 16'h0800, 16'h1000, 16'h1100, 16'h1200, 16'h3400,
        16'h3500, 16'h2201, 16'h0F00};
    logic [7:0] sp_tab [6] = '{8'h40, 8'h05, 8'h3C, 8'h11, 8'h66, 8'h22};
    logic [7:0] ro_tab [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h10};
    logic [7:0] fq_tab [4] = '{8'h40, 8'h83, 8'hC7, 8'h0F};
    always #2 i_clk = ~i_clk;
    tmor_regs dut_u (.*);
    tmor_conv_model conv_u (.i_clk(i_clk), .i_rst(i_rst), .i_req(o_conv_req),
        .i_chan(o_conv_chan), .i_slow(slow), .i_raw({10'h190, 10'h190, 10'h0C8}),
        .o_done(i_meas_done), .o_chan(i_meas_chan), .o_raw(i_meas_raw));
    // ----
    // access tasks
    // ----
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_wr = 1'b1;
        i_addr = a;
        i_wdata = d;
        @(negedge i_clk);
        i_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clk);
        i_rd = 1'b1;
        i_addr = a;
        @(negedge i_clk);
        i_rd = 1'b0;
        check({7'h00, o_rvalid}, 8'h01);
        check(o_rdata, e);
    endtask
    // alert is looked at only once the pass is over
    task automatic shot(input logic go);
        wr(8'h0F, 8'h5A);
        check({7'h00, o_busy}, {7'h00, go});
        k = 0;
        while (o_busy === 1'b1 && k < 200) begin
            @(negedge i_clk);
            k++;
        end
        check({7'h00, o_busy}, 8'h00);
        repeat (4) @(negedge i_clk);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #40us;
        errors++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        for (i = 0; i < 15; i++) rd(rst_tab[i][15:8], rst_tab[i][7:0]);
        check({6'h00, o_scl_timeout_en, o_sda_timeout_en}, 8'h00);
        $display("test reset values done");
        for (i = 0; i < 6; i++) wr(8'h09 + i[7:0], sp_tab[i]);
        check(o_config, 8'h40);
        check(o_conv_rate, 8'h05);
        for (n = 0; n < 2; n++) begin
            for (i = 0; i < 6; i++) rd(8'h03 + i[7:0], sp_tab[i]);
            for (i = 0; i < 6; i++) wr(ro_tab[i], 8'hFF);
        end
        rd(8'h00, 8'h00);
        rd(8'h02, 8'hA5);
        rd(8'h10, 8'h00);
        $display("test split addresses done");
        wr(8'h11, 8'hFF);
        wr(8'h12, 8'hBF);
        wr(8'h09, 8'h48);
        wr(8'h11, 8'h04);
        wr(8'h12, 8'h7F);
        rd(8'h34, 8'h04);
        rd(8'h35, 8'h40);
        rd(8'h11, 8'h04);
        wr(8'h09, 8'h40);
        rd(8'h11, 8'hFF);
        rd(8'h12, 8'h80);
        $display("test offsets done");
        wr(8'h09, 8'h00);
        shot(1'b0);
        wr(8'h09, 8'h40);
        shot(1'b1);
        rd(8'h00, 8'h32);
        rd(8'h01, 8'h63);
        rd(8'h10, 8'h80);
        rd(8'h0F, 8'h00);
        wr(8'h09, 8'h48);
        rd(8'h01, 8'h68);
        rd(8'h10, 8'h40);
        wr(8'h09, 8'h40);
        $display("test single conversion done");
        for (n = 1; n <= 4; n++) begin
            slow = n[0];
            wr(8'h22, fq_tab[n - 1]);
            check({6'h00, o_scl_timeout_en, o_sda_timeout_en}, {6'h00, fq_tab[n - 1][7:6]});
            i_local_out_of_limit = 1'b0;
            shot(1'b1);
            i_local_out_of_limit = 1'b1;
            for (i = 1; i <= n; i++) begin
                shot(1'b1);
                check({7'h00, o_alert_req}, {7'h00, i == n});
            end
        end
        wr(8'h22, 8'h20);
        shot(1'b1);
        check({7'h00, o_alert_req}, 8'h00);
        $display("test fault queue done");
        final_report();
    end
endmodule
